/* ppm_pin_mux.sv */
`timescale 1ns/100ps
`default_nettype none
module ppm_pin_mux
    import ppm_pkg::*;
(
    input wire ppm_cfg_t cfg_i,
    input wire ppm_pair_t gen_i,
    input wire logic pp_phase_i,
    input wire logic fault_i,
    output var ppm_pair_t pins_o
);
    ppm_pair_t by_mode;

    always_comb begin
        by_mode = '{high: 1'b0, low: 1'b0};
        case (cfg_i.pin_pair_mode)
            PPM_MODE_COMPL: begin
                by_mode.high = gen_i.high;
                by_mode.low = ~gen_i.high;
            end
            PPM_MODE_REDUND: begin
                by_mode.high = gen_i.high;
                by_mode.low = gen_i.high;
            end
            PPM_MODE_PUSH_PULL: begin
                // The pins take turns carrying the pulse, one period each.
                by_mode.high = gen_i.high & ~pp_phase_i;
                by_mode.low = gen_i.high & pp_phase_i;
            end
            PPM_MODE_INDEP: begin
                by_mode = gen_i;
            end
            default: begin
                by_mode = '{high: 1'b0, low: 1'b0};
            end
        endcase
        pins_o = by_mode;
        if (cfg_i.high_override_enable) begin
            pins_o.high = cfg_i.override_value_field.high;
        end
        if (cfg_i.low_override_enable) begin
            pins_o.low = cfg_i.override_value_field.low;
        end
        // Fault forcing is last so it wins over everything else.
        if (fault_i && !cfg_i.fault_mode_select) begin
            pins_o = cfg_i.fault_state_field;
        end
    end
endmodule : ppm_pin_mux
`default_nettype wire

/* ppm_pin_pair.sv */
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module ppm_pin_pair
    import ppm_pkg::*;
(
    input wire logic CLK_I,
    input wire logic SRST_I,
    input wire logic [3:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    input wire logic GEN_HIGH_I,
    input wire logic GEN_LOW_I,
    input wire logic PERIOD_START_I,
    input wire logic FAULT_I,
    output logic PWM_HIGH_OUT_O,
    output logic PWM_LOW_OUT_O
);
    // ****************************************************************
    // Register bus
    // ****************************************************************
    ppm_cfg_t cfg, next_cfg;
    logic ack, next_ack;
    logic [31:0] rdata, next_rdata;
    logic pp_phase, next_pp_phase;
    ppm_pair_t pins, next_pins, mux_pins;
    ppm_pair_t gen_pair;
    logic req;

    // Every access waits one cycle, so the answer is always at the
    // second edge of the request.
    assign req = (AVS_READ_I | AVS_WRITE_I) & ~ack;
    assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~ack;
    assign AVS_READDATA_O = rdata;

    always_comb begin
        next_cfg = cfg;
        next_ack = req;
        next_rdata = rdata;
        if (req && AVS_WRITE_I) begin
            if (AVS_ADDRESS_I == PPM_ADDR_PIN_CTRL) begin
                if (AVS_BYTEENABLE_I[1]) begin
                    next_cfg.pin_pair_mode = ppm_mode_t'(
                        AVS_WRITEDATA_I[PPM_MODE_MSB:PPM_MODE_LSB]);
                    next_cfg.high_override_enable =
                        AVS_WRITEDATA_I[PPM_OVR_EN_HIGH_BIT];
                    next_cfg.low_override_enable =
                        AVS_WRITEDATA_I[PPM_OVR_EN_LOW_BIT];
                end
                if (AVS_BYTEENABLE_I[0]) begin
                    next_cfg.override_value_field.high =
                        AVS_WRITEDATA_I[PPM_OVR_VAL_HIGH_BIT];
                    next_cfg.override_value_field.low =
                        AVS_WRITEDATA_I[PPM_OVR_VAL_LOW_BIT];
                    next_cfg.fault_state_field.high =
                        AVS_WRITEDATA_I[PPM_FLT_VAL_HIGH_BIT];
                    next_cfg.fault_state_field.low =
                        AVS_WRITEDATA_I[PPM_FLT_VAL_LOW_BIT];
                end
            end else if (AVS_ADDRESS_I == PPM_ADDR_FAULT_CTRL) begin
                if (AVS_BYTEENABLE_I[1]) begin
                    next_cfg.fault_mode_select =
                        AVS_WRITEDATA_I[PPM_FLT_MODE_BIT];
                end
            end
        end
        if (req && AVS_READ_I) begin
            next_rdata = 32'h0000_0000;
            case (AVS_ADDRESS_I)
                PPM_ADDR_PIN_CTRL: begin
                    next_rdata[PPM_MODE_MSB:PPM_MODE_LSB] = cfg.pin_pair_mode;
                    next_rdata[PPM_OVR_EN_HIGH_BIT] = cfg.high_override_enable;
                    next_rdata[PPM_OVR_EN_LOW_BIT] = cfg.low_override_enable;
                    next_rdata[PPM_OVR_VAL_HIGH_BIT:PPM_OVR_VAL_LOW_BIT] =
                        cfg.override_value_field;
                    next_rdata[PPM_FLT_VAL_HIGH_BIT:PPM_FLT_VAL_LOW_BIT] =
                        cfg.fault_state_field;
                end
                PPM_ADDR_FAULT_CTRL: begin
                    next_rdata[PPM_FLT_MODE_BIT] = cfg.fault_mode_select;
                end
                PPM_ADDR_STATUS: begin
                    next_rdata[3:0] = {FAULT_I, pp_phase, pins.high, pins.low};
                end
                default: begin
                    next_rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            cfg <= '{pin_pair_mode: ppm_mode_t'(PPM_PIN_CTRL_RESET[11:10]),
                     high_override_enable: PPM_PIN_CTRL_RESET[9],
                     low_override_enable: PPM_PIN_CTRL_RESET[8],
                     override_value_field: PPM_PIN_CTRL_RESET[7:6],
                     fault_state_field: PPM_PIN_CTRL_RESET[5:4],
                     fault_mode_select: PPM_FLT_MODE_RESET};
            ack <= 1'b0;
            rdata <= 32'h0000_0000;
        end else begin
            cfg <= next_cfg;
            ack <= next_ack;
            rdata <= next_rdata;
        end
    end

    // ****************************************************************
    // Pin stage
    // ****************************************************************
    assign gen_pair = '{high: GEN_HIGH_I, low: GEN_LOW_I};

    ppm_pin_mux u_mux (
        .cfg_i(cfg),
        .gen_i(gen_pair),
        .pp_phase_i(pp_phase),
        .fault_i(FAULT_I),
        .pins_o(mux_pins)
    );

    always_comb begin
        next_pp_phase = PERIOD_START_I ? ~pp_phase : pp_phase;
        next_pins = mux_pins;
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            pp_phase <= 1'b0;
            pins <= '{high: 1'b0, low: 1'b0};
        end else begin
            pp_phase <= next_pp_phase;
            pins <= next_pins;
        end
    end

    assign PWM_HIGH_OUT_O = pins.high;
    assign PWM_LOW_OUT_O = pins.low;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (SRST_I);

    logic flt_now;
    assign flt_now = FAULT_I && !cfg.fault_mode_select;

    fault_high_a: assert property (flt_now |=>
        PWM_HIGH_OUT_O == $past(cfg.fault_state_field.high))
        else $error("fault did not force the high pin");
    fault_low_a: assert property (flt_now |=>
        PWM_LOW_OUT_O == $past(cfg.fault_state_field.low))
        else $error("fault did not force the low pin");
    ovr_high_a: assert property (!flt_now && cfg.high_override_enable
        |=> PWM_HIGH_OUT_O == $past(cfg.override_value_field.high))
        else $error("high override not applied");
    ovr_low_a: assert property (!flt_now && cfg.low_override_enable
        |=> PWM_LOW_OUT_O == $past(cfg.override_value_field.low))
        else $error("low override not applied");
    ovr_value_a: assert property (!flt_now
        && cfg.high_override_enable && cfg.low_override_enable
        |=> {PWM_HIGH_OUT_O, PWM_LOW_OUT_O}
            == $past(cfg.override_value_field))
        else $error("override value bits misplaced");
    compl_mode_a: assert property (!flt_now
        && !cfg.high_override_enable && !cfg.low_override_enable
        && cfg.pin_pair_mode == PPM_MODE_COMPL
        |=> PWM_HIGH_OUT_O == $past(GEN_HIGH_I)
            && PWM_LOW_OUT_O == !PWM_HIGH_OUT_O)
        else $error("complementary pins not opposite");
    redund_mode_a: assert property (!flt_now
        && !cfg.high_override_enable && !cfg.low_override_enable
        && cfg.pin_pair_mode == PPM_MODE_REDUND
        |=> PWM_LOW_OUT_O == PWM_HIGH_OUT_O
            && PWM_HIGH_OUT_O == $past(GEN_HIGH_I))
        else $error("redundant pins differ");
    push_pull_a: assert property (!flt_now
        && !cfg.high_override_enable && !cfg.low_override_enable
        && cfg.pin_pair_mode == PPM_MODE_PUSH_PULL
        |=> !(PWM_HIGH_OUT_O && PWM_LOW_OUT_O)
            && PWM_HIGH_OUT_O == $past(GEN_HIGH_I && !pp_phase)
            && PWM_LOW_OUT_O == $past(GEN_HIGH_I && pp_phase))
        else $error("push-pull pins both high");
    indep_mode_a: assert property (!flt_now
        && !cfg.high_override_enable && !cfg.low_override_enable
        && cfg.pin_pair_mode == PPM_MODE_INDEP
        |=> PWM_HIGH_OUT_O == $past(GEN_HIGH_I)
            && PWM_LOW_OUT_O == $past(GEN_LOW_I))
        else $error("independent pins do not follow generator");
    bus_answer_a: assert property ($rose(AVS_READ_I | AVS_WRITE_I)
        |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O)
        else $error("bus answer not on second edge");
    fault_first_a: assert property (flt_now
        && cfg.high_override_enable && cfg.low_override_enable
        |=> {PWM_HIGH_OUT_O, PWM_LOW_OUT_O} == $past(cfg.fault_state_field))
        else $error("override beat an active fault");
    mode_write_a: assert property (AVS_WRITE_I && AVS_WAITREQUEST_O
        && AVS_ADDRESS_I == PPM_ADDR_PIN_CTRL && AVS_BYTEENABLE_I[1]
        |=> cfg.pin_pair_mode
            == $past(AVS_WRITEDATA_I[PPM_MODE_MSB:PPM_MODE_LSB]))
        else $error("mode field write not stored");
    phase_toggle_a: assert property (PERIOD_START_I
        |=> pp_phase != $past(pp_phase))
        else $error("push-pull phase did not alternate");

    fault_seen_c: cover property (flt_now ##1 flt_now);
    override_c: cover property (cfg.high_override_enable && !flt_now);
    push_pull_c: cover property (cfg.pin_pair_mode == PPM_MODE_PUSH_PULL
        && PERIOD_START_I);
    read_c: cover property (AVS_READ_I && !AVS_WAITREQUEST_O);
endmodule : ppm_pin_pair
`default_nettype wire

/* ppm_pkg.sv */
package ppm_pkg;
    // ****************************************************************
    // Register map and field layout
    // ****************************************************************
    localparam logic [3:0] PPM_ADDR_PIN_CTRL = 4'h0;
    localparam logic [3:0] PPM_ADDR_FAULT_CTRL = 4'h4;
    localparam logic [3:0] PPM_ADDR_STATUS = 4'h8;
    localparam int PPM_MODE_MSB = 11;
    localparam int PPM_MODE_LSB = 10;
    localparam int PPM_OVR_EN_HIGH_BIT = 9;
    localparam int PPM_OVR_EN_LOW_BIT = 8;
    localparam int PPM_OVR_VAL_HIGH_BIT = 7;
    localparam int PPM_OVR_VAL_LOW_BIT = 6;
    localparam int PPM_FLT_VAL_HIGH_BIT = 5;
    localparam int PPM_FLT_VAL_LOW_BIT = 4;
    localparam int PPM_FLT_MODE_BIT = 15;
    localparam logic [11:4] PPM_PIN_CTRL_RESET = 8'h00;
    localparam logic PPM_FLT_MODE_RESET = 1'b0;

    typedef enum logic [1:0] {
        PPM_MODE_COMPL = 2'h0,
        PPM_MODE_REDUND = 2'h1,
        PPM_MODE_PUSH_PULL = 2'h2,
        PPM_MODE_INDEP = 2'h3
    } ppm_mode_t;

    typedef struct packed {
        logic high;
        logic low;
    } ppm_pair_t;

    typedef struct packed {
        ppm_mode_t pin_pair_mode;
        logic high_override_enable;
        logic low_override_enable;
        ppm_pair_t override_value_field;
        ppm_pair_t fault_state_field;
        logic fault_mode_select;
    } ppm_cfg_t;
endpackage : ppm_pkg

/* ppm_power_stage.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Half-bridge power stage seen from the pin pair
// ****************************************************************
module ppm_power_stage (
    input wire logic clk_i,
    input wire logic high_i,
    input wire logic low_i,
    output logic node_o
);
    logic node = 1'b0;
    // With both switches on or both off the node is not defined, so it
    // toggles rather than keeping a value that could hide a fault.
    always_ff @(posedge clk_i) begin
        case ({high_i, low_i})
            2'b10: node <= 1'b1;
            2'b01: node <= 1'b0;
            default: node <= ~node;
        endcase
    end
    assign node_o = node;
endmodule : ppm_power_stage
`default_nettype wire

/* testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench
    import ppm_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [3:0] be = 4'hF;
    logic [31:0] rdat;
    logic wrq;
    logic gh = 1'b0;
    logic gl = 1'b0;
    logic pst = 1'b0;
    logic flt = 1'b0;
    logic ph_o;
    logic pl_o;
    logic node;
    logic [31:0] got;
    int errors = 0;
    int cmp_count = 0;
    always #4 clk = ~clk;
    ppm_pin_pair u_ppm_pin_pair (.CLK_I(clk), .SRST_I(rst),
        .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
        .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(be),
        .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wrq),
        .GEN_HIGH_I(gh), .GEN_LOW_I(gl), .PERIOD_START_I(pst),
        .FAULT_I(flt), .PWM_HIGH_OUT_O(ph_o), .PWM_LOW_OUT_O(pl_o));
    ppm_power_stage u_ppm_power_stage (.clk_i(clk), .high_i(ph_o),
        .low_i(pl_o), .node_o(node));
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: seen %h want %h", $time, seen, exp);
        end
    endtask : chk
    // Request is held until the edge at which waitrequest is seen low.
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [31:0] d, input logic [3:0] b);
        int n;
        logic q;
        n = 0;
        q = 1'b1;
        @(posedge clk);
        wr <= w;
        rd <= ~w;
        adr <= a;
        wdat <= d;
        be <= b;
        while (q && n < 20) begin
            #1;
            q = wrq;
            got = rdat;
            @(posedge clk);
            n++;
        end
        wr <= 1'b0;
        rd <= 1'b0;
        if (q) begin
            errors++;
            $display("MISMATCH at %0t: bus timeout", $time);
            report_and_stop();
        end
    endtask : bus
    task automatic gen(input logic h, input logic l);
        @(posedge clk);
        gh <= h;
        gl <= l;
    endtask : gen
    task automatic pins(input logic [1:0] e);
        repeat (2) @(posedge clk);
        #1;
        chk({30'h0, ph_o, pl_o}, {30'h0, e});
    endtask : pins
    function automatic logic [31:0] cw(input logic [1:0] m,
        input logic [1:0] oe, input logic [1:0] ov, input logic [1:0] fs);
        return {20'h0, m, oe, ov, fs, 4'h0};
    endfunction : cw
    function automatic logic [1:0] ex(input logic [1:0] m, input logic h,
        input logic l, input logic p);
        case (m)
            2'h0: return {h, ~h};
            2'h1: return {h, h};
            2'h2: return p ? {1'b0, h} : {h, 1'b0};
            default: return {h, l};
        endcase
    endfunction : ex
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        pins(2'h1);
        bus(1'b0, PPM_ADDR_PIN_CTRL, 32'h0, 4'hF);
        chk(got, 32'h0);
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, PPM_ADDR_PIN_CTRL, cw(m[1:0], 2'h0, 2'h0, 2'h0), 4'hF);
            for (int g = 0; g < 4; g++) begin
                gen(g[1], g[0]);
                pins(ex(m[1:0], g[1], g[0], 1'b0));
            end
        end
        $display("mode test done");
        bus(1'b1, PPM_ADDR_PIN_CTRL, cw(2'h2, 2'h0, 2'h0, 2'h0), 4'hF);
        @(posedge clk);
        pst <= 1'b1;
        @(posedge clk);
        pst <= 1'b0;
        for (int g = 0; g < 4; g++) begin
            gen(g[1], g[0]);
            pins(ex(2'h2, g[1], g[0], 1'b1));
        end
        $display("push-pull phase test done");
        gen(1'b1, 1'b0);
        bus(1'b1, PPM_ADDR_PIN_CTRL, cw(2'h0, 2'h2, 2'h1, 2'h0), 4'hF);
        pins(2'h0);
        bus(1'b1, PPM_ADDR_PIN_CTRL, cw(2'h0, 2'h1, 2'h1, 2'h0), 4'hF);
        pins(2'h3);
        bus(1'b1, PPM_ADDR_PIN_CTRL, cw(2'h0, 2'h3, 2'h1, 2'h0), 4'hF);
        pins(2'h1);
        chk({31'h0, node}, 32'h0);
        bus(1'b1, PPM_ADDR_PIN_CTRL, cw(2'h0, 2'h0, 2'h2, 2'h3), 4'hE);
        bus(1'b0, PPM_ADDR_PIN_CTRL, 32'h0, 4'hF);
        chk(got, cw(2'h0, 2'h0, 2'h1, 2'h0));
        $display("override test done");
        bus(1'b1, PPM_ADDR_PIN_CTRL, cw(2'h1, 2'h3, 2'h2, 2'h1), 4'hF);
        pins(2'h2);
        @(posedge clk);
        flt <= 1'b1;
        pins(2'h1);
        bus(1'b1, PPM_ADDR_PIN_CTRL, cw(2'h1, 2'h3, 2'h2, 2'h2), 4'hF);
        pins(2'h2);
        bus(1'b0, PPM_ADDR_STATUS, 32'h0, 4'hF);
        chk(got, 32'hE);
        bus(1'b1, PPM_ADDR_FAULT_CTRL, 32'h8000, 4'hF);
        bus(1'b0, PPM_ADDR_FAULT_CTRL, 32'h0, 4'hF);
        chk(got, 32'h0000_8000);
        bus(1'b1, PPM_ADDR_PIN_CTRL, cw(2'h1, 2'h3, 2'h1, 2'h2), 4'hF);
        pins(2'h1);
        bus(1'b1, PPM_ADDR_FAULT_CTRL, 32'h0, 4'hF);
        pins(2'h2);
        bus(1'b0, 4'hC, 32'h0, 4'hF);
        chk(got, 32'h0);
        $display("fault test done");
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
